// File: src/t3r_regs.sv
// Operation
// RULE_01: Each 16-bit register sits as low byte at base, high byte at base+1.
// RULE_02: Counter value is readable and writable by the processor.
// RULE_03: One shared 8-bit high-byte latch serves all 16-bit registers.
// RULE_04: A counter write blocks compare matches on the next timer tick.
// RULE_05: Software avoids rewriting a running counter; matches may be missed.
// RULE_06: A capture event copies the counter into the capture register.
// RULE_07: Capture register can serve as the counter TOP value.
// RULE_08: Capture reads return both bytes consistently via the shared latch.
// RULE_09: Compare A is matched continuously against the counter.
// RULE_10: Compare B is matched continuously against the counter.
// RULE_11: Compare writes update both bytes together via the shared latch.
// RULE_12: All four registers reset to zero; counter sits at offset 0x94.
// RULE_13: Capture fires on the selected edge and sets the capture flag.
// RULE_14: With capture as TOP, the capture input is ignored entirely.
// RULE_15: Low read latches high byte; high written first, low write commits.
`include "t3r_map.svh"
`timescale 1ns/1ps
module t3r_regs (
  input  wire logic          CLOCK,
  input  wire logic          RST_B,
  input  wire logic [7:0]    ADDR,
  input  wire logic [7:0]    WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  input  wire logic          TICK,
  input  wire logic          CAP_TOP,
  input  wire logic          CAPTURE_EDGE_SELECT,
  input  wire logic          CAPTURE_INPUT_PIN,
  input  wire logic          CAP_FLAG_CLR,
  output logic      [7:0]    RDATA,
  output logic      [15:0]   COUNTER_VALUE,
  output logic      [15:0]   CAPTURE_VALUE,
  output logic      [15:0]   COMPARE_A_VALUE,
  output logic      [15:0]   COMPARE_B_VALUE,
  output logic               MATCH_A,
  output logic               MATCH_B,
  output logic               CAPTURE_FLAG
);
  t3r_pkg::t3r_byte_t temp;
  t3r_pkg::t3r_word_t next_count;
  logic               block_match;
  logic               pin_prev;
  logic               cap_event;
  logic               cnt_wr;
  logic               hit_a;
  logic               hit_b;

  assign cnt_wr = WR && (ADDR == `T3R_ADDR_CNT_LO); // RULE_02
  assign cap_event = !CAP_TOP && (CAPTURE_EDGE_SELECT ? // RULE_14
    (CAPTURE_INPUT_PIN && !pin_prev) :
    (!CAPTURE_INPUT_PIN && pin_prev)); // RULE_13
  assign hit_a = TICK && !block_match &&
    (COUNTER_VALUE == COMPARE_A_VALUE); // RULE_09
  assign hit_b = TICK && !block_match &&
    (COUNTER_VALUE == COMPARE_B_VALUE); // RULE_10

  always_comb begin
    next_count = COUNTER_VALUE;
    if (TICK) begin
      if (CAP_TOP && (COUNTER_VALUE >= CAPTURE_VALUE)) begin
        next_count = `T3R_RESET_WORD; // RULE_07
      end else begin
        next_count = COUNTER_VALUE + `T3R_ONE;
      end
    end
  end

  // Shared high byte latch: filled by high writes and low reads.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      temp <= `T3R_RESET_BYTE;
    end else if (WR && ADDR[0] && ADDR >= `T3R_ADDR_CNT_LO &&
                 ADDR <= `T3R_ADDR_CMPB_HI) begin
      temp <= WDATA; // RULE_03
    end else if (RD) begin
      case (ADDR)
        `T3R_ADDR_CNT_LO:  temp <= COUNTER_VALUE[15:8]; // RULE_15
        `T3R_ADDR_CAP_LO:  temp <= CAPTURE_VALUE[15:8]; // RULE_08
        `T3R_ADDR_CMPA_LO: temp <= COMPARE_A_VALUE[15:8];
        `T3R_ADDR_CMPB_LO: temp <= COMPARE_B_VALUE[15:8];
        default:           temp <= temp;
      endcase
    end
  end

  // Read data: low bytes and compare high bytes direct, counter and capture high bytes from the latch.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= `T3R_RESET_BYTE;
    end else if (RD) begin
      case (ADDR)
        `T3R_ADDR_CNT_LO:  RDATA <= COUNTER_VALUE[7:0]; // RULE_01
        `T3R_ADDR_CAP_LO:  RDATA <= CAPTURE_VALUE[7:0];
        `T3R_ADDR_CMPA_LO: RDATA <= COMPARE_A_VALUE[7:0];
        `T3R_ADDR_CMPB_LO: RDATA <= COMPARE_B_VALUE[7:0];
        `T3R_ADDR_CNT_HI,
        `T3R_ADDR_CAP_HI:  RDATA <= temp; // RULE_08
        `T3R_ADDR_CMPA_HI: RDATA <= COMPARE_A_VALUE[15:8];
        `T3R_ADDR_CMPB_HI: RDATA <= COMPARE_B_VALUE[15:8];
        default:           RDATA <= `T3R_RESET_BYTE;
      endcase
    end
  end

  // Counter: a low-byte write commits latch and data together.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      COUNTER_VALUE <= `T3R_RESET_WORD; // RULE_12
    end else if (cnt_wr) begin
      COUNTER_VALUE <= {temp, WDATA}; // RULE_15
    end else begin
      COUNTER_VALUE <= next_count;
    end
  end

  // Match block armed by a counter write, spent on the next tick.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      block_match <= 1'b0;
    end else if (cnt_wr) begin
      block_match <= 1'b1; // RULE_04
    end else if (TICK) begin
      block_match <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      MATCH_A <= 1'b0;
      MATCH_B <= 1'b0;
    end else begin
      MATCH_A <= hit_a; // RULE_09
      MATCH_B <= hit_b; // RULE_10
    end
  end

  // Capture register: pin edge or software write of both bytes.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      CAPTURE_VALUE <= `T3R_RESET_WORD;
    end else if (cap_event) begin
      CAPTURE_VALUE <= COUNTER_VALUE; // RULE_06
    end else if (WR && ADDR == `T3R_ADDR_CAP_LO) begin
      CAPTURE_VALUE <= {temp, WDATA};
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= CAPTURE_INPUT_PIN;
    end
  end

  // Capture flag: set wins over clear.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      CAPTURE_FLAG <= 1'b0;
    end else if (cap_event) begin
      CAPTURE_FLAG <= 1'b1; // RULE_13
    end else if (CAP_FLAG_CLR) begin
      CAPTURE_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      COMPARE_A_VALUE <= `T3R_RESET_WORD;
      COMPARE_B_VALUE <= `T3R_RESET_WORD;
    end else if (WR && ADDR == `T3R_ADDR_CMPA_LO) begin
      COMPARE_A_VALUE <= {temp, WDATA}; // RULE_11
    end else if (WR && ADDR == `T3R_ADDR_CMPB_LO) begin
      COMPARE_B_VALUE <= {temp, WDATA}; // RULE_11
    end
  end
endmodule : t3r_regs

// File: shared/t3r_map.svh
`ifndef T3R_MAP_SVH
`define T3R_MAP_SVH
`define T3R_ADDR_CNT_LO  8'h94
`define T3R_ADDR_CNT_HI  8'h95
`define T3R_ADDR_CAP_LO  8'h96
`define T3R_ADDR_CAP_HI  8'h97
`define T3R_ADDR_CMPA_LO 8'h98
`define T3R_ADDR_CMPA_HI 8'h99
`define T3R_ADDR_CMPB_LO 8'h9A
`define T3R_ADDR_CMPB_HI 8'h9B
`define T3R_RESET_WORD   16'h0000
`define T3R_RESET_BYTE   8'h00
`define T3R_ONE          16'h0001
`endif

// File: shared/t3r_pkg.sv
package t3r_pkg;
  typedef logic [15:0] t3r_word_t;
  typedef logic [7:0]  t3r_byte_t;
endpackage : t3r_pkg

// File: sim/t3r_regs_props.sv
`timescale 1ns/1ps
module t3r_props (input logic CLOCK, RST_B, WR, RD, TICK, CAP_TOP,
  MATCH_A, MATCH_B, CAPTURE_FLAG, input logic [7:0] ADDR, WDATA, RDATA,
  input logic [15:0] COUNTER_VALUE, CAPTURE_VALUE, COMPARE_A_VALUE,
  COMPARE_B_VALUE);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  sequence s_hi_lo; WR && ADDR == 8'h99 ##1 WR && ADDR == 8'h98; endsequence
  sequence s_rd_lo_hi; RD && ADDR == 8'h94 ##1 RD && ADDR == 8'h95; endsequence
  property p_rst; $rose(RST_B) |-> (COUNTER_VALUE | CAPTURE_VALUE |
    COMPARE_A_VALUE | COMPARE_B_VALUE) == 16'h0000; endproperty
  property p_tick; TICK && !CAP_TOP && !WR |=>
    COUNTER_VALUE == $past(COUNTER_VALUE) + 16'h0001; endproperty
  property p_ma; MATCH_A |-> $past(TICK) &&
    $past(COUNTER_VALUE) == $past(COMPARE_A_VALUE); endproperty
  property p_mb; MATCH_B |-> $past(TICK) &&
    $past(COUNTER_VALUE) == $past(COMPARE_B_VALUE); endproperty
  property p_blk; WR && ADDR == 8'h94 ##1 TICK |=> !MATCH_A && !MATCH_B;
  endproperty
  property p_blk2; WR && ADDR == 8'h94 ##1 !TICK && !WR ##1 TICK |=>
    !MATCH_A && !MATCH_B; endproperty
  property p_cmp; s_hi_lo |=>
    COMPARE_A_VALUE == {$past(WDATA, 2), $past(WDATA)}; endproperty
  property p_top; CAP_TOP [*2] |=> !$rose(CAPTURE_FLAG); endproperty
  property p_rd; s_rd_lo_hi |=> RDATA == $past(COUNTER_VALUE[15:8], 2);
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  a_tick: assert property (p_tick) else $error("count step");
  a_ma: assert property (p_ma) else $error("match a");
  a_mb: assert property (p_mb) else $error("match b");
  a_blk: assert property (p_blk) else $error("not blocked");
  a_blk2: assert property (p_blk2) else $error("late block");
  a_cmp: assert property (p_cmp) else $error("compare write");
  a_top: assert property (p_top) else $error("capture on");
  a_rd: assert property (p_rd) else $error("high read");
endmodule : t3r_props
bind t3r_regs t3r_props u_props (.CLOCK, .RST_B, .WR, .RD, .TICK, .CAP_TOP,
  .MATCH_A, .MATCH_B, .CAPTURE_FLAG, .ADDR, .WDATA, .RDATA, .COUNTER_VALUE,
  .CAPTURE_VALUE, .COMPARE_A_VALUE, .COMPARE_B_VALUE);

// File: sim/t3r_cpu.sv
`timescale 1ns/1ps
module t3r_cpu (input logic CLOCK, input logic [7:0] RDATA,
  output logic [7:0] ADDR, WDATA, output logic WR, RD);
  initial {ADDR, WDATA, WR, RD} = 18'h00000;
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    @(negedge CLOCK) {ADDR, WDATA, WR} = {a + 8'h01, v[15:8], 1'b1};
    @(negedge CLOCK) {ADDR, WDATA} = {a, v[7:0]};
    @(negedge CLOCK) {WDATA, WR} = {~WDATA, 1'b0};
  endtask : wr16
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    @(negedge CLOCK) {ADDR, RD} = {a, 1'b1};
    @(negedge CLOCK) ADDR = a + 8'h01;
    v[7:0] = RDATA;
    @(negedge CLOCK) RD = 1'b0;
    v[15:8] = RDATA;
  endtask : rd16
endmodule : t3r_cpu

// File: sim/tb_t3r_regs.sv
`timescale 1ns/1ps
module tb_t3r_regs;
  logic CLOCK = 0, RST_B = 0, TICK = 0, CAP_TOP = 0, CAPTURE_EDGE_SELECT = 1;
  logic CAPTURE_INPUT_PIN = 0, CAP_FLAG_CLR = 0, WR, RD, MATCH_A, MATCH_B;
  logic CAPTURE_FLAG;
  logic [7:0] ADDR, WDATA, RDATA;
  logic [15:0] COUNTER_VALUE, CAPTURE_VALUE, COMPARE_A_VALUE, COMPARE_B_VALUE;
  logic [15:0] v, r;
  int err_count = 0, total_checks = 0;
  always #20 CLOCK = ~CLOCK;
  t3r_cpu u_cpu (.CLOCK, .RDATA, .ADDR, .WDATA, .WR, .RD);
  t3r_regs u_dut (.CLOCK, .RST_B, .ADDR, .WDATA, .WR, .RD, .TICK, .CAP_TOP,
    .CAPTURE_EDGE_SELECT, .CAPTURE_INPUT_PIN, .CAP_FLAG_CLR, .RDATA,
    .COUNTER_VALUE, .CAPTURE_VALUE, .COMPARE_A_VALUE, .COMPARE_B_VALUE,
    .MATCH_A, .MATCH_B, .CAPTURE_FLAG);
  task automatic check(input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic tick;
    @(negedge CLOCK) TICK = 1;
    @(negedge CLOCK) TICK = 0;
  endtask : tick
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h82E2));
    repeat (8) @(negedge CLOCK);
    RST_B = 1;
    for (int i = 0; i < 4; i++) begin
      u_cpu.rd16(8'h94 + 8'(2 * i), r);
      check(r, 16'h0000);
    end
    $display("reset test done");
    v = 16'($urandom);
    u_cpu.wr16(8'h98, v);
    u_cpu.wr16(8'h9A, v + 16'h0001);
    u_cpu.wr16(8'h94, v);
    u_cpu.rd16(8'h98, r);
    check(r, v);
    u_cpu.rd16(8'h94, r);
    check(r, v);
    tick();
    check(MATCH_A, 1'b0);
    tick();
    check(MATCH_B, 1'b1);
    u_cpu.wr16(8'h98, v + 16'h0002);
    tick();
    check(MATCH_A, 1'b1);
    u_cpu.wr16(8'h94, v + 16'h0001);
    tick();
    check(MATCH_B, 1'b0);
    $display("match test done");
    CAPTURE_INPUT_PIN = 1;
    for (int i = 0; i < 8 && CAPTURE_FLAG !== 1'b1; i++) @(negedge CLOCK);
    check(CAPTURE_FLAG, 1'b1);
    u_cpu.rd16(8'h96, r);
    check(r, v + 16'h0002);
    {CAP_FLAG_CLR, CAP_TOP, CAPTURE_EDGE_SELECT} = 3'h6;
    @(negedge CLOCK) {CAP_FLAG_CLR, CAPTURE_INPUT_PIN} = 2'h0;
    repeat (4) @(negedge CLOCK);
    check(CAPTURE_FLAG, 1'b0);
    $display("capture test done");
    complete_run();
  end
endmodule : tb_t3r_regs
